// [psmc_top.sv]
// Power save mode controller: clock gating, standby entry and wake-up
// Functional notes
// - Cpu-gated standby stops CPU clock only
// - Cpu-gated standby entered only by halt
// - Oscillator and PLL run in cpu-gated standby
// - Oscillator-only standby keeps only watch domain
// - Watch prescaler runs, peripheral prescaler stops
// - Flash power off in oscillator-only standby
// - Full-stop standby halts clock generator entirely
// - Deep standbys entered only by software write
// - Cpu-gated standby holds I/O and state
// - Clock out pin runs when enabled and port does not inhibit; holds in deep standby
// - Fetch until prefetch queue full, then stop
// - Wake on NMI, unmasked interrupt, or reset
// - Any unmasked request wakes, any priority
// - Lower priority inside handler wakes, stays pending
// - Higher priority inside handler acknowledged at wake when interrupts are enabled
// - NMI branches; maskable depends on enable state
// - Higher newer request branches to its vector
// - Reset wake equals ordinary device reset
// - Standby control bits self-clear on cancel
`timescale 1ns/1ps
module psmc_top
  import psmc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic reset_pin,
  input wire logic halt_exec,
  input wire logic prefetch_full,
  input wire logic psc_wr,
  input wire logic psc_wr_watch,
  input wire logic psc_wr_stop,
  input wire logic nmi_req,
  input wire logic mint_req,
  input wire logic [PSMC_PRIO_W-1:0] mint_prio,
  input wire logic in_handler,
  input wire logic [PSMC_PRIO_W-1:0] cur_prio,
  input wire logic interrupts_enabled_state,
  input wire logic clock_output_enable,
  input wire logic port_inhibit,
  output logic [4:0] mode_q,
  output logic cpu_clk_en_q,
  output logic periph_clk_en_q,
  output logic watch_clk_en_q,
  output logic periph_tick_q,
  output logic watch_tick_q,
  output logic osc_run_q,
  output logic pll_run_q,
  output logic flash_power_q,
  output logic io_hold_q,
  output logic cpu_clock_out_pin_q,
  output logic intc_on_q,
  output logic regulator_on_q,
  output logic reset_circuit_on_q,
  output logic psc_watch_q,
  output logic psc_stop_q,
  output logic wake_q,
  output logic ack_q,
  output logic branch_q,
  output logic next_instr_q,
  output logic sys_reset_q
);
  // ----------------------------------------
  // Reset pin synchroniser
  // ----------------------------------------
  logic rpin_meta_q;
  logic rpin_sync_q;
  logic hard_rst;

  always_ff @(posedge clock) begin
    if (rst) begin
      rpin_meta_q <= 1'b0;
      rpin_sync_q <= 1'b0;
    end else begin
      rpin_meta_q <= reset_pin;
      rpin_sync_q <= rpin_meta_q;
    end
  end

  // Reset pin acts like the ordinary reset in every mode
  assign hard_rst = rst | rpin_sync_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      sys_reset_q <= 1'b1;
    end else begin
      sys_reset_q <= rpin_sync_q;
    end
  end

  // ----------------------------------------
  // Wake arbitration
  // ----------------------------------------
  psmc_wake_if wif ();

  assign wif.nmi_req = nmi_req;
  assign wif.mint_req = mint_req;
  assign wif.mint_prio = mint_prio;
  assign wif.in_handler = in_handler;
  assign wif.cur_prio = cur_prio;
  assign wif.ints_enabled = interrupts_enabled_state;

  psmc_wake_arb u_arb (
    .w(wif.arb)
  );

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  psmc_mode_e mode_d;
  psmc_mode_e mode_r;
  logic standby;
  logic waking;

  assign standby = mode_r != PSMC_NORMAL;
  assign waking = standby && wif.wake;

  always_comb begin
    mode_d = mode_r;
    case (mode_r)
      PSMC_NORMAL: begin
        if (halt_exec) begin
          mode_d = PSMC_DRAIN;
        end else if (psc_wr && psc_wr_stop) begin
          mode_d = PSMC_STOP;
        end else if (psc_wr && psc_wr_watch) begin
          mode_d = PSMC_WATCH;
        end
      end
      PSMC_DRAIN: begin
        if (wif.wake) begin
          mode_d = PSMC_NORMAL;
        end else if (prefetch_full) begin
          mode_d = PSMC_HALT;
        end
      end
      PSMC_HALT: begin
        if (wif.wake) begin
          mode_d = PSMC_NORMAL;
        end
      end
      PSMC_WATCH: begin
        if (wif.wake) begin
          mode_d = PSMC_NORMAL;
        end
      end
      PSMC_STOP: begin
        // Interrupt controller stays alive to see this
        if (wif.wake) begin
          mode_d = PSMC_NORMAL;
        end
      end
      default: begin
        mode_d = PSMC_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (hard_rst) begin
      mode_r <= PSMC_NORMAL;
    end else begin
      mode_r <= mode_d;
    end
  end

  always_ff @(posedge clock) begin
    if (hard_rst) begin
      mode_q <= PSMC_NORMAL;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ----------------------------------------
  // Control bits, cleared when the mode ends
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (hard_rst) begin
      psc_watch_q <= 1'b0;
      psc_stop_q <= 1'b0;
    end else if (mode_d == PSMC_NORMAL) begin
      psc_watch_q <= 1'b0;
      psc_stop_q <= 1'b0;
    end else begin
      psc_watch_q <= mode_d == PSMC_WATCH;
      psc_stop_q <= mode_d == PSMC_STOP;
    end
  end

  // ----------------------------------------
  // Clock gating per mode
  // ----------------------------------------
  logic periph_run;
  logic watch_run;

  // Drain keeps the CPU clock so the prefetch queue can fill
  assign periph_run = (mode_d == PSMC_NORMAL) || (mode_d == PSMC_DRAIN) || (mode_d == PSMC_HALT);
  assign watch_run = periph_run || (mode_d == PSMC_WATCH);

  always_ff @(posedge clock) begin
    if (hard_rst) begin
      cpu_clk_en_q <= 1'b1;
      periph_clk_en_q <= 1'b1;
      watch_clk_en_q <= 1'b1;
    end else begin
      cpu_clk_en_q <= (mode_d == PSMC_NORMAL) || (mode_d == PSMC_DRAIN);
      periph_clk_en_q <= periph_run;
      watch_clk_en_q <= watch_run;
    end
  end

  always_ff @(posedge clock) begin
    if (hard_rst) begin
      osc_run_q <= 1'b1;
      pll_run_q <= 1'b1;
    end else begin
      osc_run_q <= mode_d != PSMC_STOP;
      pll_run_q <= periph_run;
    end
  end

  always_ff @(posedge clock) begin
    if (hard_rst) begin
      flash_power_q <= 1'b1;
    end else begin
      flash_power_q <= mode_d != PSMC_WATCH;
    end
  end

  // Always-on blocks; held high so wake sources are never lost
  always_ff @(posedge clock) begin
    if (rst) begin
      intc_on_q <= 1'b0;
      regulator_on_q <= 1'b0;
      reset_circuit_on_q <= 1'b0;
    end else begin
      intc_on_q <= 1'b1;
      regulator_on_q <= 1'b1;
      reset_circuit_on_q <= 1'b1;
    end
  end

  // CPU state and pins frozen in halt, watch and stop standby, not while draining
  always_ff @(posedge clock) begin
    if (hard_rst) begin
      io_hold_q <= 1'b0;
    end else begin
      io_hold_q <= (mode_d == PSMC_HALT) || (mode_d == PSMC_WATCH) || (mode_d == PSMC_STOP);
    end
  end

  // ----------------------------------------
  // Prescalers
  // ----------------------------------------
  psmc_prescaler u_periph_pre (
    .clock(clock),
    .rst(hard_rst),
    .run(periph_run),
    .div(PSMC_PERIPH_DIV),
    .tick_q(periph_tick_q)
  );

  psmc_prescaler u_watch_pre (
    .clock(clock),
    .rst(hard_rst),
    .run(watch_run),
    .div(PSMC_WATCH_DIV),
    .tick_q(watch_tick_q)
  );

  // ----------------------------------------
  // Processor clock output pin
  // ----------------------------------------
  // Deep standby stops the prescaler, so the pin just holds its level
  always_ff @(posedge clock) begin
    if (hard_rst) begin
      cpu_clock_out_pin_q <= 1'b0;
    end else if (!clock_output_enable || port_inhibit) begin
      cpu_clock_out_pin_q <= 1'b0;
    end else if (periph_tick_q) begin
      cpu_clock_out_pin_q <= ~cpu_clock_out_pin_q;
    end
  end

  // ----------------------------------------
  // Wake outcome to CPU and interrupt controller
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (hard_rst) begin
      wake_q <= 1'b0;
      ack_q <= 1'b0;
      branch_q <= 1'b0;
      next_instr_q <= 1'b0;
    end else begin
      wake_q <= waking;
      ack_q <= waking && wif.ack;
      branch_q <= waking && wif.branch;
      next_instr_q <= waking && !wif.branch;
    end
  end
endmodule

// [psmc_pkg.sv]
// Constants and types for the power save mode control block
package psmc_pkg;
  // ----------------------------------------
  // Mode states, one-hot
  // ----------------------------------------
  typedef enum logic [4:0] {
    PSMC_NORMAL = 5'h01,
    PSMC_DRAIN  = 5'h02,
    PSMC_HALT   = 5'h04,
    PSMC_WATCH  = 5'h08,
    PSMC_STOP   = 5'h10
  } psmc_mode_e;

  // ----------------------------------------
  // Widths and counts
  // ----------------------------------------
  localparam int PSMC_PRIO_W = 3;
  localparam int PSMC_DIV_W = 4;
  localparam logic [3:0] PSMC_PERIPH_DIV = 4'h3;
  localparam logic [3:0] PSMC_WATCH_DIV = 4'hf;
  localparam logic [3:0] PSMC_DIV_RESET = 4'h0;
  localparam int PSMC_RST_SYNC_STAGES = 2;
endpackage

// [psmc_wake_if.sv]
// Wake request bundle between the mode controller and its arbiter
`timescale 1ns/1ps
interface psmc_wake_if;
  import psmc_pkg::*;
  logic nmi_req;
  logic mint_req;
  logic [PSMC_PRIO_W-1:0] mint_prio;
  logic in_handler;
  logic [PSMC_PRIO_W-1:0] cur_prio;
  logic ints_enabled;
  logic wake;
  logic ack;
  logic branch;
  modport ctrl (output nmi_req, mint_req, mint_prio, in_handler, cur_prio, ints_enabled,
                input wake, ack, branch);
  modport arb (input nmi_req, mint_req, mint_prio, in_handler, cur_prio, ints_enabled,
               output wake, ack, branch);
endinterface

// [psmc_wake_arb.sv]
// Wake-up decision from interrupt priority and enable state
`timescale 1ns/1ps
module psmc_wake_arb
  import psmc_pkg::*;
(
  psmc_wake_if.arb w
);
  // ----------------------------------------
  // Priority compare, lower value wins
  // ----------------------------------------
  function automatic logic outranks(input logic [PSMC_PRIO_W-1:0] req,
                                    input logic [PSMC_PRIO_W-1:0] cur);
    outranks = req < cur;
  endfunction

  logic higher;

  always_comb begin
    // Any unmasked request wakes, whatever its level
    w.wake = w.nmi_req | w.mint_req;
    higher = w.nmi_req | (w.mint_req & (!w.in_handler | outranks(w.mint_prio, w.cur_prio)));
    // Lower level inside a handler wakes but stays pending
    w.ack = w.nmi_req | (higher & w.ints_enabled);
    // Newer higher request is taken with the wake
    w.branch = w.ack;
  end
endmodule

// [psmc_prescaler.sv]
// Gated divider giving one-cycle tick enables
`timescale 1ns/1ps
module psmc_prescaler
  import psmc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic run,
  input wire logic [PSMC_DIV_W-1:0] div,
  output logic tick_q
);
  logic [PSMC_DIV_W-1:0] cnt_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q <= PSMC_DIV_RESET;
    end else if (run) begin
      cnt_q <= (cnt_q == div) ? PSMC_DIV_RESET : cnt_q + 4'h1;
    end
  end

  // Stopped prescaler holds its count, so it resumes in phase
  always_ff @(posedge clock) begin
    if (rst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= run && (cnt_q == div);
    end
  end
endmodule

// [psmc_cpu_model.sv]
// Behavioural CPU prefetch queue facing the mode controller
`timescale 1ns/1ps
module psmc_cpu_model (
  input logic clock,
  input logic rst,
  input logic [4:0] mode_q,
  input logic [3:0] lag,
  output logic prefetch_full
);
  logic [3:0] cnt_q;
  // Queue fills lag cycles after the drain starts, never sooner
  always_ff @(posedge clock) begin
    if (rst || mode_q != 5'h02) cnt_q <= 4'h0;
    else if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
  end
  assign prefetch_full = mode_q == 5'h02 && cnt_q >= lag;
endmodule

// [psmc_checker.sv]
// Assertion checker for the power save mode controller
`timescale 1ns/1ps
module psmc_checker
  import psmc_pkg::*;
(
  input logic clock,
  input logic rst,
  input logic reset_pin,
  input logic halt_exec,
  input logic psc_wr,
  input logic psc_wr_stop,
  input logic nmi_req,
  input logic mint_req,
  input logic [PSMC_PRIO_W-1:0] mint_prio,
  input logic in_handler,
  input logic [PSMC_PRIO_W-1:0] cur_prio,
  input logic interrupts_enabled_state,
  input logic clock_output_enable,
  input logic port_inhibit,
  input logic [4:0] mode_q,
  input logic cpu_clk_en_q,
  input logic periph_clk_en_q,
  input logic watch_clk_en_q,
  input logic osc_run_q,
  input logic pll_run_q,
  input logic flash_power_q,
  input logic io_hold_q,
  input logic cpu_clock_out_pin_q,
  input logic intc_on_q,
  input logic regulator_on_q,
  input logic reset_circuit_on_q,
  input logic psc_watch_q,
  input logic psc_stop_q,
  input logic wake_q,
  input logic ack_q,
  input logic branch_q,
  input logic next_instr_q,
  input logic sys_reset_q
);
  // ----------
  // Helpers
  // ----------
  default clocking @(posedge clock); endclocking
  default disable iff (rst || sys_reset_q);
  wire req = nmi_req || mint_req;
  // Strict compare: an equal level must not preempt
  wire ack_exp = nmi_req || (interrupts_enabled_state && (!in_handler || mint_prio < cur_prio));
  sequence halt_req_s;
    mode_q == 5'h01 && halt_exec;
  endsequence
  sequence wake_req_s;
    mode_q != 5'h01 && req;
  endsequence
  // ----------
  // Assertions
  // ----------
  halt_entry_a: assert property (halt_req_s |=> mode_q == 5'h02 && cpu_clk_en_q)
    else $error("halt entry");
  halt_gate_a: assert property (mode_q == 5'h04 |-> !cpu_clk_en_q && periph_clk_en_q
    && pll_run_q && io_hold_q)
    else $error("halt gating");
  watch_gate_a: assert property (mode_q == 5'h08 |-> watch_clk_en_q && !periph_clk_en_q && !flash_power_q)
    else $error("watch gating");
  stop_gate_a: assert property (mode_q == 5'h10 |-> !osc_run_q && !pll_run_q && !watch_clk_en_q)
    else $error("stop gating");
  deep_entry_a: assert property (mode_q == 5'h01 && psc_wr && psc_wr_stop && !halt_exec |=> mode_q == 5'h10)
    else $error("stop entry");
  wake_ack_a: assert property (wake_req_s |=> wake_q && mode_q == 5'h01 && ack_q == $past(ack_exp))
    else $error("wake ack");
  branch_pair_a: assert property (wake_q |-> branch_q == ack_q && next_instr_q == !ack_q
    && !psc_watch_q && !psc_stop_q)
    else $error("wake branch");
  pin_reset_a: assert property (disable iff (rst) reset_pin [*5] |-> sys_reset_q && mode_q == 5'h01)
    else $error("pin reset");
  clk_out_off_a: assert property (!clock_output_enable || port_inhibit |=> !cpu_clock_out_pin_q)
    else $error("clock out inhibit");
  always_on_a: assert property (!rst |=> intc_on_q && regulator_on_q && reset_circuit_on_q)
    else $error("always on");
endmodule
bind psmc_top psmc_checker psmc_checker_i (.*);

// [psmc_top_tb.sv]
// Self-checking bench for the power save mode controller
`timescale 1ns/1ps
module psmc_top_tb
  import psmc_pkg::*;
;
  typedef struct packed {
    logic [1:0] m;
    logic [9:0] req;
    logic ack;
  } psmc_row_s;
  logic clock, rst, reset_pin, halt_exec, prefetch_full, psc_wr, psc_wr_watch, psc_wr_stop;
  logic nmi_req, mint_req, in_handler, interrupts_enabled_state, clock_output_enable, port_inhibit;
  logic [PSMC_PRIO_W-1:0] mint_prio, cur_prio;
  logic [4:0] mode_q;
  logic cpu_clk_en_q, periph_clk_en_q, watch_clk_en_q, periph_tick_q, watch_tick_q, osc_run_q, pll_run_q;
  logic flash_power_q, io_hold_q, cpu_clock_out_pin_q, intc_on_q, regulator_on_q, reset_circuit_on_q;
  logic psc_watch_q, psc_stop_q, wake_q, ack_q, branch_q, next_instr_q, sys_reset_q, pin_l;
  int err_count = 0;
  int checks_done = 0;
  int pc, wc, tc, n;
  logic [6:0] gv;
  psmc_row_s r;
  // Mode, nmi, mint, prio, in handler, cur prio, enabled, ack
  psmc_row_s rows [8] = '{13'h0401, 13'h0203, 13'h0200, 13'h02b7, 13'h03b6, 13'h0de3, 13'h12c3, 13'h0b32};
  psmc_top psmc_top_i (.*);
  psmc_cpu_model psmc_cpu_model_i (.clock(clock), .rst(rst), .mode_q(mode_q), .lag(4'h3),
    .prefetch_full(prefetch_full));
  // ----------
  // Tasks
  // ----------
  task step(input int k = 1);
    repeat (k) @(posedge clock);
    #2;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Code 3 is a write with both bits clear
  task enter(input logic [1:0] m);
    halt_exec = m == 2'h0;
    psc_wr = m != 2'h0;
    psc_wr_watch = m == 2'h1;
    psc_wr_stop = m == 2'h2;
    step();
    halt_exec = 0;
    psc_wr = 0;
  endtask
  task wake_nmi;
    nmi_req = 1;
    step();
    chk({mode_q, psc_watch_q, wake_q}, {5'h01, 1'b0, 1'b1});
    nmi_req = 0;
    step();
  endtask
  // ----------
  // Stimulus
  // ----------
  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    #50us;
    err_count++;
    close_out();
  end
  initial begin
    {rst, reset_pin, halt_exec, psc_wr, psc_wr_watch, psc_wr_stop, nmi_req, mint_req} = 8'h80;
    {mint_prio, in_handler, cur_prio, interrupts_enabled_state, port_inhibit} = 9'h0;
    clock_output_enable = 1;
    step(5);
    rst = 0;
    step(2);
    chk({intc_on_q, regulator_on_q, reset_circuit_on_q, sys_reset_q}, 4'he);
    foreach (rows[i]) begin
      r = rows[i];
      enter(r.m);
      if (r.m == 2'h0) begin
        chk({mode_q, cpu_clk_en_q}, {5'h02, 1'b1});
        n = 0;
        while (mode_q !== 5'h04 && n < 20) begin
          step();
          n++;
        end
        chk({mode_q, cpu_clk_en_q}, {5'h04, 1'b0});
      end
      else chk({mode_q, psc_watch_q, psc_stop_q}, {r.m == 2'h1 ? 5'h08 : 5'h10, r.m == 2'h1, r.m == 2'h2});
      pc = 0;
      wc = 0;
      tc = 0;
      pin_l = cpu_clock_out_pin_q;
      repeat (32) begin
        step();
        pc += periph_tick_q;
        wc += watch_tick_q;
        tc += cpu_clock_out_pin_q != pin_l;
        pin_l = cpu_clock_out_pin_q;
      end
      chk({pc[3:0], wc[3:0], tc[3:0]}, r.m == 2'h0 ? 12'h828 : (r.m == 2'h1 ? 12'h020 : 12'h000));
      gv = {cpu_clk_en_q, periph_clk_en_q, watch_clk_en_q, osc_run_q, pll_run_q, flash_power_q, io_hold_q};
      chk(gv, r.m == 2'h0 ? 7'h3f : (r.m == 2'h1 ? 7'h19 : 7'h03));
      {nmi_req, mint_req, mint_prio, in_handler, cur_prio, interrupts_enabled_state} = r.req;
      step();
      chk({mode_q, wake_q, ack_q, branch_q, next_instr_q}, {5'h01, 1'b1, r.ack, r.ack, !r.ack});
      chk({psc_watch_q, psc_stop_q, cpu_clk_en_q}, 3'h1);
      {nmi_req, mint_req} = 2'h0;
      step();
      chk(wake_q, 1'b0);
    end
    enter(2'h3);
    chk(mode_q, 5'h01);
    step();
    enter(2'h1);
    step();
    enter(2'h0);
    chk(mode_q, 5'h08);
    wake_nmi();
    {psc_wr, psc_wr_watch, psc_wr_stop} = 3'h7;
    step();
    psc_wr = 0;
    chk(mode_q, 5'h10);
    wake_nmi();
    // Wake while the prefetch queue is still filling
    enter(2'h0);
    wake_nmi();
    enter(2'h0);
    port_inhibit = 1;
    step(8);
    chk({mode_q, cpu_clock_out_pin_q}, {5'h04, 1'b0});
    reset_pin = 1;
    step(6);
    chk({sys_reset_q, mode_q, io_hold_q}, {1'b1, 5'h01, 1'b0});
    reset_pin = 0;
    step(5);
    chk({sys_reset_q, intc_on_q}, 2'h1);
    port_inhibit = 0;
    clock_output_enable = 0;
    tc = 0;
    repeat (8) begin
      step();
      tc += cpu_clock_out_pin_q;
    end
    chk(tc[3:0], 4'h0);
    close_out();
  end
endmodule
